//--- igpf_defs.vh
`ifndef IGPF_DEFS_VH
`define IGPF_DEFS_VH

// ==========================================
// Register byte offsets
`define IGPF_OFS_CTRL 12'h000
`define IGPF_OFS_IRQ_CFG 12'h004
`define IGPF_OFS_GP_DIR 12'h008
`define IGPF_OFS_GP_OUT 12'h00C
`define IGPF_OFS_GP_IN 12'h010
`define IGPF_OFS_INT_STAT 12'h014
`define IGPF_OFS_INT_EN 12'h018
`define IGPF_OFS_INT_CLR 12'h01C

// ==========================================
// Field positions
`define IGPF_CTRL_GP_SEL 0
`define IGPF_CTRL_BUS_MODE 1
`define IGPF_IRQ_EN_LSB 4
`define IGPF_IRQ_EN_MSB 7
`define IGPF_POL_LSB 0
`define IGPF_POL_MSB 3
`define IGPF_STAT_NMI 0
`define IGPF_STAT_EXT_LSB 1
`define IGPF_STAT_EXT_MSB 4

// ==========================================
// Reset values
`define IGPF_RST_CTRL 2'h0
`define IGPF_RST_IRQ_CFG 8'h00
`define IGPF_RST_DIR 16'h0000
`define IGPF_RST_OUT 16'h0000
`define IGPF_RST_INT_EN 5'h00

`endif

//--- igpf_edge_det.v
`timescale 1ns/100ps
// ==========================================
// Two-stage synchroniser and edge detector
module igpf_edge_det #(
	parameter WIDTH = 4
) (
	input wire i_clk,
	input wire i_rst,
	input wire [WIDTH-1:0] i_async,
	input wire [WIDTH-1:0] i_fall_sel,
	output wire [WIDTH-1:0] o_sync,
	output wire [WIDTH-1:0] o_edge
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;
	reg [WIDTH-1:0] prev_q;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
			prev_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign o_sync = sync_q;
	// Rising when select clear, falling when set
	assign o_edge = (~i_fall_sel & sync_q & ~prev_q) | (i_fall_sel & ~sync_q & prev_q);
endmodule

//--- igpf_pin_logic.v
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "igpf_defs.vh"
// How it works
// - Rising edge on nonmaskable input raises a request; level alone does not.
// - After reset the four shared pins are inputs only, drivers off.
// - Shared pin is external interrupt only while its enable bit 7..4 set.
// - External interrupts are edge triggered; each edge chosen by its polarity bit.
// - After reset pins 15..9 have no active function unless the bus-enable strap is set.
// - Bus mode: pin 15 takes bus reset, pin 14 bus clock, inputs only.
// - Bus mode: pin 13 drives interrupt A, pin 11 request, both floatable; 12 grant.
// - Bus mode: pin 10 is byte-enable lane 3 bidirectional; pin 9 device select in.
// - A pin selected as general-purpose may be input, output or high impedance.
// - Bus-enable strap decides host/general pins or bus pins on 15..9.
module igpf_pin_logic (
	input wire i_clk,
	input wire i_rst,
	// APB
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output wire o_pready,
	output reg [31:0] o_prdata,
	output wire o_pslverr,
	// Pins
	input wire i_nmi,
	input wire i_bus_enable_strap,
	input wire [3:0] i_ext_pin,
	output wire [3:0] o_ext_pin,
	output wire [3:0] o_ext_pin_oe,
	input wire [6:0] i_hi_pin,
	output wire [6:0] o_hi_pin,
	output wire [6:0] o_hi_pin_oe,
	// Core side
	output wire o_nmi_req,
	output wire [3:0] o_ext_irq_req,
	output wire o_irq,
	output wire o_bus_mode,
	output reg o_bus_reset_in,
	output reg o_bus_clk_in,
	output reg o_bus_grant_in,
	output reg o_bus_init_device_select,
	output reg o_bus_cmd_byte_enable_3_in,
	input wire i_bus_interrupt_a_out,
	input wire i_bus_interrupt_a_oe,
	input wire i_bus_request_out,
	input wire i_bus_request_oe,
	input wire i_bus_cmd_byte_enable_3_out,
	input wire i_bus_cmd_byte_enable_3_oe
);
	// ==========================================
	// Registers
	reg [1:0] ctrl_q;
	reg [7:0] irq_cfg_q;
	reg [15:0] dir_q;
	reg [15:0] out_q;
	reg [4:0] stat_q;
	reg [4:0] int_en_q;
	reg strap_meta_q;
	reg strap_sync_q;
	reg strap_seen_q;
	reg bus_mode_q;
	reg [6:0] hi_meta_q;
	reg [6:0] hi_sync_q;

	wire [3:0] irq_enable_bits;
	wire [3:0] ext_irq_edge_select;
	wire [3:0] ext_sync;
	wire [3:0] ext_edge;
	wire nmi_sync;
	wire nmi_edge;
	wire wr_en;
	wire [4:0] ev;
	wire gp_hi_active;
	wire [15:0] gp_in;

	assign irq_enable_bits = irq_cfg_q[`IGPF_IRQ_EN_MSB:`IGPF_IRQ_EN_LSB];
	assign ext_irq_edge_select = irq_cfg_q[`IGPF_POL_MSB:`IGPF_POL_LSB];

	// ==========================================
	// Edge detection
	igpf_edge_det #(.WIDTH(1)) u_nmi_det (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_async(i_nmi),
		.i_fall_sel(1'b0),
		.o_sync(nmi_sync),
		.o_edge(nmi_edge)
	);

	igpf_edge_det #(.WIDTH(4)) u_ext_det (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_async(i_ext_pin),
		.i_fall_sel(ext_irq_edge_select),
		.o_sync(ext_sync),
		.o_edge(ext_edge)
	);

	assign o_nmi_req = nmi_edge;
	assign o_ext_irq_req = ext_edge & irq_enable_bits;

	// ==========================================
	// Strap synchronised and followed every cycle after reset release
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			strap_meta_q <= 1'b0;
			strap_sync_q <= 1'b0;
			strap_seen_q <= 1'b0;
			bus_mode_q <= 1'b0;
		end else begin
			strap_meta_q <= i_bus_enable_strap;
			strap_sync_q <= strap_meta_q;
			strap_seen_q <= 1'b1;
			if (strap_seen_q) begin
				bus_mode_q <= strap_sync_q;
			end
		end
	end
	assign o_bus_mode = bus_mode_q;

	// ==========================================
	// Upper pin input synchroniser
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			hi_meta_q <= 7'h00;
			hi_sync_q <= 7'h00;
		end else begin
			hi_meta_q <= i_hi_pin;
			hi_sync_q <= hi_meta_q;
		end
	end

	// Bus-side inputs, idle unless bus mode
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_bus_reset_in <= 1'b0;
			o_bus_clk_in <= 1'b0;
			o_bus_grant_in <= 1'b0;
			o_bus_init_device_select <= 1'b0;
			o_bus_cmd_byte_enable_3_in <= 1'b0;
		end else begin
			o_bus_reset_in <= bus_mode_q & hi_sync_q[6];
			o_bus_clk_in <= bus_mode_q & hi_sync_q[5];
			o_bus_grant_in <= bus_mode_q & hi_sync_q[3];
			o_bus_cmd_byte_enable_3_in <= bus_mode_q & hi_sync_q[1];
			o_bus_init_device_select <= bus_mode_q & hi_sync_q[0];
		end
	end

	// ==========================================
	// Pin drivers
	assign gp_hi_active = ~bus_mode_q & ctrl_q[`IGPF_CTRL_GP_SEL];
	// Shared pins: driven only as GPIO outputs with interrupt off
	assign o_ext_pin = out_q[7:4];
	assign o_ext_pin_oe = dir_q[7:4] & ~irq_enable_bits;

	// Pins 15..9: no drive until GPIO selected or bus mode
	assign o_hi_pin = bus_mode_q ?
		{1'b0, 1'b0, i_bus_interrupt_a_out, 1'b0, i_bus_request_out, i_bus_cmd_byte_enable_3_out, 1'b0} :
		out_q[15:9];
	assign o_hi_pin_oe = bus_mode_q ?
		{2'b00, i_bus_interrupt_a_oe, 1'b0, i_bus_request_oe, i_bus_cmd_byte_enable_3_oe, 1'b0} :
		(gp_hi_active ? dir_q[15:9] : 7'h00);

	assign gp_in = {gp_hi_active ? hi_sync_q : 7'h00, 1'b0, ext_sync, 4'h0};

	// ==========================================
	// Interrupt status
	assign ev = {o_ext_irq_req, nmi_edge};
	assign wr_en = i_psel & i_penable & i_pwrite;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			stat_q <= 5'h00;
		end else if (wr_en && i_paddr == `IGPF_OFS_INT_CLR) begin
			stat_q <= (stat_q & ~i_pwdata[4:0]) | ev;
		end else begin
			stat_q <= stat_q | ev;
		end
	end
	assign o_irq = |(stat_q & int_en_q);

	// ==========================================
	// APB slave
	assign o_pready = 1'b1;
	assign o_pslverr = 1'b0;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_q <= `IGPF_RST_CTRL;
			irq_cfg_q <= `IGPF_RST_IRQ_CFG;
			dir_q <= `IGPF_RST_DIR;
			out_q <= `IGPF_RST_OUT;
			int_en_q <= `IGPF_RST_INT_EN;
		end else if (wr_en) begin
			if (i_paddr == `IGPF_OFS_CTRL) begin
				ctrl_q[`IGPF_CTRL_GP_SEL] <= i_pwdata[`IGPF_CTRL_GP_SEL];
			end else if (i_paddr == `IGPF_OFS_IRQ_CFG) begin
				irq_cfg_q <= i_pwdata[7:0];
			end else if (i_paddr == `IGPF_OFS_GP_DIR) begin
				dir_q <= i_pwdata[15:0];
			end else if (i_paddr == `IGPF_OFS_GP_OUT) begin
				out_q <= i_pwdata[15:0];
			end else if (i_paddr == `IGPF_OFS_INT_EN) begin
				int_en_q <= i_pwdata[4:0];
			end
		end
	end

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_prdata <= 32'h0000_0000;
		end else if (i_psel && !i_penable && !i_pwrite) begin
			if (i_paddr == `IGPF_OFS_CTRL) begin
				o_prdata <= {30'h0000_0000, bus_mode_q, ctrl_q[`IGPF_CTRL_GP_SEL]};
			end else if (i_paddr == `IGPF_OFS_IRQ_CFG) begin
				o_prdata <= {24'h00_0000, irq_cfg_q};
			end else if (i_paddr == `IGPF_OFS_GP_DIR) begin
				o_prdata <= {16'h0000, dir_q};
			end else if (i_paddr == `IGPF_OFS_GP_OUT) begin
				o_prdata <= {16'h0000, out_q};
			end else if (i_paddr == `IGPF_OFS_GP_IN) begin
				o_prdata <= {16'h0000, gp_in};
			end else if (i_paddr == `IGPF_OFS_INT_STAT) begin
				o_prdata <= {27'h000_0000, stat_q};
			end else if (i_paddr == `IGPF_OFS_INT_EN) begin
				o_prdata <= {27'h000_0000, int_en_q};
			end else begin
				o_prdata <= 32'h0000_0000;
			end
		end
	end
endmodule

//--- igpf_assertions.sv
`timescale 1ns/100ps
// ==========================================
// Port checker
module igpf_assertions (
	input wire i_clk,
	input wire i_rst,
	input wire i_nmi,
	input wire o_nmi_req,
	input wire [3:0] o_ext_irq_req,
	input wire [3:0] o_ext_pin_oe,
	input wire [6:0] o_hi_pin,
	input wire [6:0] o_hi_pin_oe,
	input wire o_bus_mode,
	input wire o_bus_reset_in,
	input wire i_bus_request_out,
	input wire i_bus_request_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	property p_nmi; o_nmi_req |-> $past(i_nmi, 2) ##1 !o_nmi_req; endproperty
	a_nmi: assert property (p_nmi) else $error("nmi request without input edge");
	property p_ext_oe; (o_ext_irq_req & o_ext_pin_oe) == 4'h0; endproperty
	a_ext_oe: assert property (p_ext_oe) else $error("interrupt pin driven");
	property p_ext; o_ext_irq_req != 4'h0 |=> (o_ext_irq_req & $past(o_ext_irq_req)) == 4'h0; endproperty
	a_ext: assert property (p_ext) else $error("edge request longer than a cycle");
	property p_rst_ext; $fell(i_rst) |-> o_ext_pin_oe == 4'h0; endproperty
	a_rst_ext: assert property (p_rst_ext) else $error("shared pin driven after reset");
	property p_rst_hi; $fell(i_rst) |-> o_hi_pin_oe == 7'h00 ##1 o_hi_pin_oe == 7'h00; endproperty
	a_rst_hi: assert property (p_rst_hi) else $error("high pin driven after reset");
	property p_bus_in; o_bus_mode |-> (o_hi_pin_oe & 7'h69) == 7'h00; endproperty
	a_bus_in: assert property (p_bus_in) else $error("bus input pin driven");
	property p_bus_req;
		o_bus_mode |-> o_hi_pin_oe[2] == i_bus_request_oe && (!i_bus_request_oe || o_hi_pin[2] == i_bus_request_out);
	endproperty
	a_bus_req: assert property (p_bus_req) else $error("bus request pin wrong");
	property p_strap; !o_bus_mode && !$past(o_bus_mode) |-> !o_bus_reset_in; endproperty
	a_strap: assert property (p_strap) else $error("bus input outside bus mode");
endmodule

//--- igpf_pin_env.sv
`timescale 1ns/100ps
// ==========================================
// Far side: interrupt sources and bus host
module igpf_pin_env (
	input wire logic [3:0] i_src_ext,
	input wire logic [6:0] i_src_hi,
	input wire logic [3:0] i_dev_ext,
	input wire logic [3:0] i_dev_ext_oe,
	input wire logic [6:0] i_dev_hi,
	input wire logic [6:0] i_dev_hi_oe,
	output logic [3:0] o_ext_wire,
	output logic [6:0] o_hi_wire
);
	// Device wins while it drives
	assign o_ext_wire = (i_dev_ext_oe & i_dev_ext) | (~i_dev_ext_oe & i_src_ext);
	assign o_hi_wire = (i_dev_hi_oe & i_dev_hi) | (~i_dev_hi_oe & i_src_hi);
endmodule

//--- tb.sv
`timescale 1ns/100ps
`include "igpf_defs.vh"
module tb;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, nmi = 0, strap = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, r, k;
	logic pready, nmi_req, irq, bmode, brst, bclk, bgnt, bids, bcbe, slverr;
	logic [3:0] src = 4'h0, ext_in, ext_out, ext_oe, pol;
	logic [6:0] hsrc = 7'h00, hi_in, hi_out, hi_oe;
	logic [5:0] bo = 6'h00;
	integer seed = 40154, miscompares = 0, n_tests = 0, n;
	always #2.5 clk = ~clk;
	igpf_pin_logic dut (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(slverr), .i_nmi(nmi),
		.i_bus_enable_strap(strap), .i_ext_pin(ext_in), .o_ext_pin(ext_out), .o_ext_pin_oe(ext_oe),
		.i_hi_pin(hi_in), .o_hi_pin(hi_out), .o_hi_pin_oe(hi_oe), .o_nmi_req(nmi_req), .o_ext_irq_req(),
		.o_irq(irq), .o_bus_mode(bmode), .o_bus_reset_in(brst), .o_bus_clk_in(bclk), .o_bus_grant_in(bgnt),
		.o_bus_init_device_select(bids), .o_bus_cmd_byte_enable_3_in(bcbe), .i_bus_interrupt_a_out(bo[0]),
		.i_bus_interrupt_a_oe(bo[1]), .i_bus_request_out(bo[2]), .i_bus_request_oe(bo[3]),
		.i_bus_cmd_byte_enable_3_out(bo[4]), .i_bus_cmd_byte_enable_3_oe(bo[5]));
	igpf_pin_env env (.i_src_ext(src), .i_src_hi(hsrc), .i_dev_ext(ext_out), .i_dev_ext_oe(ext_oe),
		.i_dev_hi(hi_out), .i_dev_hi_oe(hi_oe), .o_ext_wire(ext_in), .o_hi_wire(hi_in));
	function automatic [31:0] exp_stat(input logic [3:0] p, input integer i, input logic up);
		exp_stat = (p[i] != up) ? (32'h0000_0002 << i) : 32'h0000_0000;
	endfunction
	task final_report;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
			miscompares++;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		integer t;
		t = 0;
		@(posedge clk);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1 && t < 16) begin
			@(posedge clk);
			t++;
		end
		r = prdata;
		psel <= 0; penable <= 0;
		// One more edge so register-driven outputs have settled
		@(posedge clk);
		if (t == 16) begin
			miscompares++;
			final_report;
		end
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 32'h0000_0000);
		chk(r, e);
	endtask
	task step(input logic [3:0] s);
		src <= s;
		repeat (8) @(posedge clk);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 0;
		rd(`IGPF_OFS_CTRL, 32'h0000_0000);
		rd(`IGPF_OFS_IRQ_CFG, 32'h0000_0000);
		rd(`IGPF_OFS_GP_DIR, 32'h0000_0000);
		rd(12'h020, 32'h0000_0000);
		chk(32'(slverr), 32'h0000_0000);
		step(4'hF);
		rd(`IGPF_OFS_GP_IN, 32'h0000_00F0);
		step(4'h0);
		rd(`IGPF_OFS_INT_STAT, 32'h0000_0000);
		$display("test reset done");
		pol = $random(seed);
		apb(1, `IGPF_OFS_IRQ_CFG, {24'h00_0000, 4'hF, pol});
		apb(1, `IGPF_OFS_INT_EN, 32'h0000_001F);
		for (n = 0; n < 4; n++) begin
			step(4'h1 << n);
			rd(`IGPF_OFS_INT_STAT, exp_stat(pol, n, 1));
			apb(1, `IGPF_OFS_INT_CLR, 32'h0000_001F);
			step(4'h0);
			rd(`IGPF_OFS_INT_STAT, exp_stat(pol, n, 0));
			apb(1, `IGPF_OFS_INT_CLR, 32'h0000_001F);
		end
		$display("test edges done");
		apb(1, `IGPF_OFS_INT_EN, 32'h0000_0000);
		nmi <= 1;
		repeat (8) @(posedge clk);
		rd(`IGPF_OFS_INT_STAT, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
		apb(1, `IGPF_OFS_INT_EN, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0001);
		apb(1, `IGPF_OFS_INT_CLR, 32'h0000_0001);
		repeat (8) @(posedge clk);
		rd(`IGPF_OFS_INT_STAT, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		nmi <= 0;
		$display("test nmi done");
		apb(1, `IGPF_OFS_IRQ_CFG, 32'h0000_0000);
		apb(1, `IGPF_OFS_GP_DIR, 32'h0000_0010);
		apb(1, `IGPF_OFS_GP_OUT, 32'h0000_0010);
		chk(32'({ext_oe, ext_out}), 32'h0000_0011);
		apb(1, `IGPF_OFS_IRQ_CFG, 32'h0000_0010);
		chk(32'(ext_oe), 32'h0000_0000);
		k = $random(seed);
		apb(1, `IGPF_OFS_GP_DIR, k & 32'h0000_FE00);
		chk(32'(hi_oe), 32'h0000_0000);
		apb(1, `IGPF_OFS_CTRL, 32'h0000_0001);
		chk(32'(hi_oe), 32'(k[15:9]));
		$display("test gpio done");
		strap <= 1;
		rst <= 1;
		repeat (8) @(posedge clk);
		rst <= 0;
		repeat (8) @(posedge clk);
		rd(`IGPF_OFS_CTRL, 32'h0000_0002);
		apb(1, `IGPF_OFS_CTRL, 32'h0000_0000);
		rd(`IGPF_OFS_CTRL, 32'h0000_0002);
		hsrc <= 7'h6B;
		bo <= 6'h0C;
		repeat (8) @(posedge clk);
		chk(32'({brst, bclk}), 32'h0000_0003);
		chk(32'(hi_oe), 32'h0000_0004);
		chk(32'({bgnt, hi_out[2]}), 32'h0000_0003);
		chk(32'({bcbe, bids}), 32'h0000_0003);
		$display("test bus done");
		final_report;
	end
endmodule
bind igpf_pin_logic igpf_assertions u_chk (.i_clk, .i_rst, .i_nmi, .o_nmi_req, .o_ext_irq_req, .o_ext_pin_oe,
	.o_hi_pin, .o_hi_pin_oe, .o_bus_mode, .o_bus_reset_in, .i_bus_request_out, .i_bus_request_oe);
